/* File: logic/lbm_master.sv */
// Local bus master: address, data, wait and recovery sequencing
//
// Behaviour
// (R1) Byte-lane pattern of each word is latched and held until ready is sampled.
// (R2) After ready, next data phase carries next pattern; last word releases the lanes.
// (R3) Byte-lane patterns issued are always contiguous.
// (R4) Ready is active low; missing ready inserts a wait phase.
// (R5) Read-modify-write read asserts lock in address phase and keeps it.
// (R6) If lock is already held by another, wait before the locked read.
// (R7) Read-modify-write write releases lock in its address phase.
// (R8) Lock is asserted throughout interrupt acknowledge.
// (R9) Other masters keep off the bus while lock is asserted.
// (R10) Cacheable driven in address phase, floated when the bus is not owned.
// (R11) Bus phases run at half the input clock rate; bus clock is output.
// (R12) One to four words move per issued address.
// (R13) Read address phase: address, size, both strobes, lanes, write/read and direction low.
// (R14) Read data phase: transceiver enable on, data sampled when ready asserted.
// (R15) One recovery bus clock follows the last word; controls go inactive.
// (R16) Write address phase: address, size, both strobes, lanes, write/read and direction high.
// (R17) Write data phase: data driven and held while ready stays deasserted.
// (R18) Write/read, direction and enable hold until the phase after ready.
// (R19) External logic asserts ready low when data is placed or accepted.
// (R20) Any transaction may directly precede or follow another.
// (R21) Size code on the two low lines, zero meaning one word.
// (R22) Direction never changes while transceiver enable is asserted.
// (R23) Address latch strobe asserted in address phase, removed before data phase.
// (R24) Latch, status, enable and byte-lane strobes are active low.
`timescale 1ns/1ns
module lbm_master import lbm_pkg::*; (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Request stream from the core
    input wire logic req_valid_i,
    output logic req_ready_o,
    input wire lbm_req_s req_i,
    // Read data to the core
    output logic rd_valid_o,
    output lbm_rdata_s rd_o,
    // Bus clock for peripherals
    output logic bus_clk_o,
    // Shared address/data lines
    input wire logic [31:0] shared_addr_data_lines_i,
    output logic [31:0] shared_addr_data_lines_o,
    output logic shared_addr_data_lines_oe_o,
    // Address latch strobe, three-state
    output logic ale_n_o,
    output logic ale_oe_o,
    // Open-drain controls
    output logic address_status_strobe_n_o,
    output logic address_status_strobe_oe_o,
    output logic transfer_direction_o,
    output logic transfer_direction_oe_o,
    output logic transceiver_enable_n_o,
    output logic transceiver_enable_oe_o,
    output logic write_read_o,
    output logic write_read_oe_o,
    output logic [3:0] byte_lane_strobes_n_o,
    output logic [3:0] byte_lane_strobes_oe_o,
    // Ready and lock
    input wire logic ready_n_i,
    input wire logic lock_n_i,
    output logic lock_n_o,
    output logic lock_oe_o,
    // Cacheable, three-state
    output logic cache_o,
    output logic cache_oe_o
);
    logic rst_meta_q;
    logic rst_n_q;
    logic tick;
    logic buf_valid;
    logic buf_take;
    lbm_req_s buf_req;
    lbm_req_s nxt_req;
    lbm_req_s cur_q;
    lbm_state_e st_q;
    lbm_state_e st_d;
    logic [1:0] wcnt_q;
    logic ready_meta_q;
    logic ready_s_q;
    logic lock_meta_q;
    logic lock_s_q;
    logic [31:0] lad_meta_q;
    logic [31:0] lad_s_q;
    logic word_done;
    logic last_word;
    logic lock_busy;
    logic [3:0] be_next;
    logic [31:0] lad_q;
    logic lad_oe_q;
    logic ale_q;
    logic ads_q;
    logic dir_oe_q;
    logic wr_oe_q;
    logic den_q;
    logic [3:0] be_q;
    logic lock_q;
    logic cache_q;
    logic cache_oe_q;
    logic rd_valid_q;
    lbm_rdata_s rd_q;

    // Reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    lbm_phase_gen u_phase (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .tick_o(tick),
        .bus_clk_o(bus_clk_o) // [R11]
    );

    // A full buffer stalls the core; no request is lost
    lbm_req_buf #(
        .WIDTH(LBM_REQ_W),
        .DEPTH(LBM_BUF_DEPTH)
    ) u_buf (
        .clk_i(clk_i),
        .rst_n_i(rst_n_q),
        .in_valid_i(req_valid_i),
        .in_ready_o(req_ready_o),
        .in_data_i(req_i),
        .out_valid_o(buf_valid),
        .out_ready_i(buf_take),
        .out_data_o(buf_req)
    );

    // Pin inputs pass two flops; data is delayed alike so it stays aligned with ready
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ready_meta_q <= 1'b1;
            ready_s_q <= 1'b1;
            lock_meta_q <= 1'b1;
            lock_s_q <= 1'b1;
            lad_meta_q <= LBM_LAD_RST;
            lad_s_q <= LBM_LAD_RST;
        end else begin
            ready_meta_q <= ready_n_i;
            ready_s_q <= ready_meta_q;
            lock_meta_q <= lock_n_i;
            lock_s_q <= lock_meta_q;
            lad_meta_q <= shared_addr_data_lines_i;
            lad_s_q <= lad_meta_q;
        end
    end

    // Fill gaps between lowest and highest lane
    function automatic logic [3:0] lbm_contig(input logic [3:0] be);
        logic [3:0] lo;
        logic [3:0] hi;
        lo = '0;
        hi = '0;
        for (int i = 0; i < 4; i++) begin
            lo[i] = (i == 0) ? be[0] : (lo[i-1] | be[i]);
            hi[3-i] = (i == 0) ? be[3] : (hi[4-i] | be[3-i]);
        end
        return lo & hi;
    endfunction

    assign word_done = (st_q == LBM_ST_DATA || st_q == LBM_ST_WAIT) && !ready_s_q; // [R4] [R19]
    assign last_word = (wcnt_q == cur_q.size); // [R12]
    // Own lock reads back low; only a foreign holder blocks
    assign lock_busy = !lock_s_q && !lock_q; // [R6] [R9]
    assign be_next = lbm_contig(cur_q.be[wcnt_q + 2'h1]); // [R3]
    assign buf_take = tick && buf_valid && (st_q == LBM_ST_IDLE || st_q == LBM_ST_RECOV);
    assign nxt_req = (st_q == LBM_ST_LOCK_WAIT) ? cur_q : buf_req;

    // Next bus state, evaluated at each bus clock boundary
    always_comb begin
        st_d = st_q;
        case (st_q)
            LBM_ST_IDLE, LBM_ST_RECOV: begin
                if (!buf_valid) begin
                    st_d = LBM_ST_IDLE;
                end else if (lbm_lock_e'(buf_req.lock_op) == LBM_LOCK_RMW_READ && lock_busy) begin
                    st_d = LBM_ST_LOCK_WAIT; // [R6]
                end else begin
                    st_d = LBM_ST_ADDR; // [R20]
                end
            end
            LBM_ST_LOCK_WAIT: begin
                if (!lock_busy) begin
                    st_d = LBM_ST_ADDR; // [R6]
                end
            end
            LBM_ST_ADDR: begin
                st_d = LBM_ST_DATA;
            end
            LBM_ST_DATA, LBM_ST_WAIT: begin
                if (!word_done) begin
                    st_d = LBM_ST_WAIT; // [R4]
                end else if (last_word) begin
                    st_d = LBM_ST_RECOV; // [R15]
                end else begin
                    st_d = LBM_ST_DATA; // [R12]
                end
            end
            default: begin
                st_d = LBM_ST_IDLE;
            end
        endcase
    end

    // Bus state and current request
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= LBM_ST_IDLE;
            cur_q <= '0;
            wcnt_q <= LBM_WCNT_RST;
        end else if (tick) begin
            st_q <= st_d; // [R11]
            if (buf_take) begin
                cur_q <= buf_req;
            end
            if (st_d == LBM_ST_ADDR) begin
                wcnt_q <= LBM_WCNT_RST;
            end else if (word_done) begin
                wcnt_q <= wcnt_q + 2'h1;
            end
        end
    end

    // Shared lines: address and size, then write data held through waits
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lad_q <= LBM_LAD_RST;
            lad_oe_q <= 1'b0;
        end else if (tick) begin
            if (st_d == LBM_ST_ADDR) begin
                lad_q <= '0;
                lad_q[31:LBM_ADDR_LSB] <= nxt_req.addr; // [R13] [R16]
                lad_q[LBM_ADDR_LSB-1:LBM_SIZE_LSB] <= nxt_req.size; // [R21]
                lad_oe_q <= 1'b1;
            end else if (st_d == LBM_ST_DATA && st_q == LBM_ST_ADDR) begin
                lad_q <= cur_q.wdata[0]; // [R17]
                lad_oe_q <= cur_q.write;
            end else if (st_d == LBM_ST_DATA && word_done) begin
                lad_q <= cur_q.wdata[wcnt_q + 2'h1];
                lad_oe_q <= cur_q.write;
            end else if (st_d != LBM_ST_WAIT) begin
                lad_oe_q <= 1'b0; // [R15]
            end
        end
    end

    // Address latch strobe: first half of the address phase only
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ale_q <= 1'b0;
        end else begin
            ale_q <= tick && (st_d == LBM_ST_ADDR); // [R23]
        end
    end

    // Address status: address phase, and again for each further burst word
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ads_q <= 1'b0;
        end else if (tick) begin
            ads_q <= (st_d == LBM_ST_ADDR) || (st_d == LBM_ST_DATA && word_done); // [R13] [R16]
        end
    end

    // Direction, write/read and transceiver enable
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            dir_oe_q <= 1'b0;
            wr_oe_q <= 1'b0;
            den_q <= 1'b0;
        end else if (tick) begin
            case (st_d)
                LBM_ST_ADDR: begin
                    // Pulled low means read; released means write
                    dir_oe_q <= !nxt_req.write; // [R13] [R16]
                    wr_oe_q <= !nxt_req.write;
                    den_q <= 1'b0; // [R22]
                end
                LBM_ST_DATA, LBM_ST_WAIT: begin
                    den_q <= 1'b1; // [R14] [R17] [R18]
                end
                default: begin
                    dir_oe_q <= 1'b0; // [R15]
                    wr_oe_q <= 1'b0;
                    den_q <= 1'b0;
                end
            endcase
        end
    end

    // Byte lanes latched per word and held until ready
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            be_q <= LBM_BE_RST;
        end else if (tick) begin
            if (st_d == LBM_ST_ADDR) begin
                be_q <= lbm_contig(nxt_req.be[0]); // [R1] [R3]
            end else if (st_d == LBM_ST_DATA && word_done) begin
                be_q <= be_next; // [R2]
            end else if (st_d != LBM_ST_DATA && st_d != LBM_ST_WAIT) begin
                be_q <= LBM_BE_RST; // [R2]
            end
        end
    end

    // Bus lock for locked read, locked write and interrupt acknowledge
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            lock_q <= 1'b0;
        end else if (tick) begin
            if (st_d == LBM_ST_ADDR) begin
                case (lbm_lock_e'(nxt_req.lock_op))
                    LBM_LOCK_RMW_READ: begin
                        lock_q <= 1'b1; // [R5]
                    end
                    LBM_LOCK_RMW_WRITE: begin
                        lock_q <= 1'b0; // [R7]
                    end
                    LBM_LOCK_INTACK: begin
                        lock_q <= 1'b1; // [R8]
                    end
                    default: begin
                        lock_q <= lock_q
                            && !(st_q == LBM_ST_RECOV && lbm_lock_e'(cur_q.lock_op) == LBM_LOCK_INTACK); // [R8]
                    end
                endcase
            end else if (st_q == LBM_ST_RECOV && lbm_lock_e'(cur_q.lock_op) == LBM_LOCK_INTACK) begin
                lock_q <= 1'b0; // [R8]
            end
        end
    end

    // Cacheable: valid in address phase, floated when idle
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cache_q <= 1'b0;
            cache_oe_q <= 1'b0;
        end else if (tick) begin
            if (st_d == LBM_ST_ADDR) begin
                cache_q <= nxt_req.cache; // [R10]
            end
            cache_oe_q <= (st_d != LBM_ST_IDLE) && (st_d != LBM_ST_LOCK_WAIT); // [R10]
        end
    end

    // Read data capture on the ready boundary
    always_ff @(posedge clk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rd_valid_q <= 1'b0;
            rd_q <= '0;
        end else begin
            rd_valid_q <= tick && word_done && !cur_q.write; // [R14]
            if (tick && word_done && !cur_q.write) begin
                rd_q.data <= lad_s_q;
                rd_q.last <= last_word;
            end
        end
    end

    // Pin drivers; open-drain enables follow assertion
    assign shared_addr_data_lines_o = lad_q;
    assign shared_addr_data_lines_oe_o = lad_oe_q;
    assign ale_n_o = !ale_q; // [R24]
    assign ale_oe_o = cache_oe_q;
    assign address_status_strobe_n_o = LBM_OD_LEVEL;
    assign address_status_strobe_oe_o = ads_q; // [R24]
    assign transfer_direction_o = LBM_OD_LEVEL;
    assign transfer_direction_oe_o = dir_oe_q;
    assign transceiver_enable_n_o = LBM_OD_LEVEL;
    assign transceiver_enable_oe_o = den_q; // [R24]
    assign write_read_o = LBM_OD_LEVEL;
    assign write_read_oe_o = wr_oe_q;
    assign byte_lane_strobes_n_o = {4{LBM_OD_LEVEL}};
    assign byte_lane_strobes_oe_o = be_q; // [R24]
    assign lock_n_o = LBM_OD_LEVEL;
    assign lock_oe_o = lock_q;
    assign cache_o = cache_q;
    assign cache_oe_o = cache_oe_q;
    assign rd_valid_o = rd_valid_q;
    assign rd_o = rd_q;
endmodule

/* File: logic/lbm_pkg.sv */
// Shared constants and types of the local bus master
package lbm_pkg;
    // Clock and bus timing
    localparam int LBM_CLK_PERIOD_NS = 8;
    localparam int LBM_CLKS_PER_BUS = 2;
    localparam int LBM_RECOV_BUS_CLKS = 1;
    localparam int LBM_RECOV_CLKS = LBM_RECOV_BUS_CLKS * LBM_CLKS_PER_BUS;
    localparam int LBM_SYNC_STAGES = 2;
    localparam int LBM_BUF_DEPTH = 2;

    // Address phase field positions on the shared lines
    localparam int LBM_SIZE_LSB = 0;
    localparam int LBM_ADDR_LSB = 2;

    // Size codes, binary ascending from one word
    localparam logic [1:0] LBM_SIZE_ONE = 2'h0;
    localparam logic [1:0] LBM_SIZE_FOUR = 2'h3;

    // Values after reset
    localparam logic [31:0] LBM_LAD_RST = 32'h0000_0000;
    localparam logic [3:0] LBM_BE_RST = 4'h0;
    localparam logic [1:0] LBM_WCNT_RST = 2'h0;
    localparam logic LBM_OD_LEVEL = 1'b0;

    typedef enum {
        LBM_LOCK_NONE,
        LBM_LOCK_RMW_READ,
        LBM_LOCK_RMW_WRITE,
        LBM_LOCK_INTACK
    } lbm_lock_e;

    typedef enum {
        LBM_ST_IDLE,
        LBM_ST_LOCK_WAIT,
        LBM_ST_ADDR,
        LBM_ST_DATA,
        LBM_ST_WAIT,
        LBM_ST_RECOV
    } lbm_state_e;

    // One transaction request; be is active high, one pattern per word
    typedef struct packed {
        logic [29:0] addr;
        logic [1:0] size;
        logic write;
        logic cache;
        logic [1:0] lock_op;
        logic [3:0][3:0] be;
        logic [3:0][31:0] wdata;
    } lbm_req_s;

    localparam int LBM_REQ_W = $bits(lbm_req_s);

    // Read data returned to the core
    typedef struct packed {
        logic [31:0] data;
        logic last;
    } lbm_rdata_s;
endpackage

/* File: logic/lbm_req_buf.sv */
// Two-entry request buffer with valid/ready on both sides
`timescale 1ns/1ns
module lbm_req_buf import lbm_pkg::*; #(
    parameter int WIDTH = LBM_REQ_W,
    parameter int DEPTH = LBM_BUF_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Filling side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Draining side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [PW-1:0] wr_ptr_q;
    logic [PW-1:0] rd_ptr_q;
    logic [PW:0] count_q;
    logic push;
    logic pop;

    assign in_ready_o = (count_q != DEPTH[PW:0]);
    assign out_valid_o = (count_q != '0);
    assign out_data_o = mem_q[rd_ptr_q];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_ff @(posedge clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= '0;
            count_q <= '0;
        end else begin
            if (push) begin
                wr_ptr_q <= wr_ptr_q + 1'b1;
            end
            if (pop) begin
                rd_ptr_q <= rd_ptr_q + 1'b1;
            end
            if (push && !pop) begin
                count_q <= count_q + 1'b1;
            end else if (pop && !push) begin
                count_q <= count_q - 1'b1;
            end
        end
    end
endmodule

/* File: logic/lbm_phase_gen.sv */
// Half-rate bus clock and phase tick from the double-rate input clock
`timescale 1ns/1ns
module lbm_phase_gen (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_n_i,
    // Phase outputs
    output logic tick_o,
    output logic bus_clk_o
);
    logic ph_q;

    // Bus state boundaries fall on every second input edge
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ph_q <= 1'b0;
        end else begin
            ph_q <= ~ph_q;
        end
    end

    assign tick_o = ph_q;
    assign bus_clk_o = ph_q;
endmodule

/* File: testbench/lbm_master_monitor.sv */
// Port timing checker of the local bus master
`timescale 1ns/1ns
module lbm_master_monitor (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Watched ports
    input wire logic bus_clk_o,
    input wire logic ale_n_o,
    input wire logic address_status_strobe_oe_o,
    input wire logic transfer_direction_oe_o,
    input wire logic transceiver_enable_oe_o,
    input wire logic write_read_oe_o,
    input wire logic [3:0] byte_lane_strobes_oe_o,
    input wire logic [31:0] shared_addr_data_lines_o,
    input wire logic shared_addr_data_lines_oe_o,
    input wire logic ready_n_i,
    input wire logic lock_oe_o,
    input wire logic cache_oe_o,
    input wire logic rd_valid_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!arst_n_i);
    // Ready reaches the sequencer two edges late
    sequence s_stall;
        bus_clk_o && transceiver_enable_oe_o && $past(ready_n_i, 2);
    endsequence
    sequence s_quiet;
        (ale_n_o && !address_status_strobe_oe_o) [*2];
    endsequence
    a_wait_holds: assert property (s_stall |=> transceiver_enable_oe_o
        && $stable(byte_lane_strobes_oe_o) && $stable(write_read_oe_o)
        && (!shared_addr_data_lines_oe_o || $stable(shared_addr_data_lines_o)))
        else $error("Wait phase moved");
    a_read_done: assert property (bus_clk_o && transceiver_enable_oe_o && write_read_oe_o
        && !$past(ready_n_i, 2) |-> ##[1:2] rd_valid_o)
        else $error("Read word lost");
    a_dir_steady: assert property (transceiver_enable_oe_o && $past(transceiver_enable_oe_o)
        |-> $stable(transfer_direction_oe_o))
        else $error("Direction moved");
    a_ale_short: assert property (!ale_n_o |=> ale_n_o && !transceiver_enable_oe_o
        ##1 transceiver_enable_oe_o)
        else $error("Latch strobe late");
    a_addr_drive: assert property (!ale_n_o |-> shared_addr_data_lines_oe_o
        && address_status_strobe_oe_o && transfer_direction_oe_o == write_read_oe_o && cache_oe_o)
        else $error("Address phase wrong");
    a_recovery_gap: assert property ($fell(transceiver_enable_oe_o) |-> !write_read_oe_o
        && !transfer_direction_oe_o ##0 s_quiet)
        else $error("No recovery");
    a_half_rate: assert property (bus_clk_o |=> !bus_clk_o ##1 bus_clk_o)
        else $error("Bus clock rate");
    a_lanes_contig: assert property (byte_lane_strobes_oe_o inside
        {4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he, 4'hf})
        else $error("Lanes gap");
    a_lock_start: assert property ($rose(lock_oe_o) |-> !ale_n_o)
        else $error("Lock raised late");
endmodule

bind lbm_master lbm_master_monitor mon_u (.*);

/* File: testbench/lbm_bus_partner.sv */
// Memory and ready logic standing on the far side of the bus
`timescale 1ns/1ns
module lbm_bus_partner (
    // Clock and reset
    input wire logic clk_i,
    input wire logic arst_n_i,
    // Master side levels
    input wire logic bus_clk_i,
    input wire logic [31:0] lad_i,
    input wire logic lad_oe_i,
    input wire logic ads_oe_i,
    input wire logic den_oe_i,
    input wire logic wr_oe_i,
    input wire logic [3:0] be_oe_i,
    input wire logic lock_oe_i,
    // Bench controls
    input wire logic [1:0] wait_i,
    input wire logic foreign_lock_i,
    // Wire levels
    output logic [31:0] lad_o,
    output logic ready_n_o,
    output logic lock_n_o
);
    logic [31:0] mem_q [16];
    logic [31:0] drv_q;
    logic drive_q, wr_q, wp_q;
    logic [3:0] idx_q, wi_q;
    logic [2:0] left_q;
    logic [1:0] wt_q;
    assign lad_o = lad_oe_i ? lad_i : drv_q;
    // Pulled-up lock; low whenever the master or the foreign holder drives it, whatever the master is doing
    assign lock_n_o = ~(lock_oe_i | foreign_lock_i);
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        logic [3:0] ni;
        logic [2:0] nl;
        logic [1:0] nw;
        logic nwr;
        if (!arst_n_i) begin
            for (int k = 0; k < 16; k++) mem_q[k] <= 32'h5a00_0000 | k;
            {drv_q, drive_q, wr_q, idx_q, left_q, wt_q, wp_q, wi_q} <= '0;
            ready_n_o <= 1'b1;
        end else begin
            // Released lines never show the last value
            if (!drive_q) drv_q <= ~lad_o;
            if (bus_clk_i) begin
                {ni, nl, nw, nwr} = {idx_q, left_q, wt_q, wr_q};
                ready_n_o <= 1'b1;
                drive_q <= 1'b0;
                // Master holds word and lanes one state past the ready window
                for (int b = 0; b < 4; b++) if (wp_q && be_oe_i[b]) mem_q[wi_q][8*b +: 8] <= lad_o[8*b +: 8];
                wp_q <= wr_q && !ready_n_o;
                wi_q <= idx_q;
                if (!ready_n_o) begin
                    ni = ni + 4'h1;
                    nl = nl - 3'h1;
                end
                if (ads_oe_i && !den_oe_i) begin
                    {ni, nl, nw, nwr} = {lad_i[5:2], {1'b0, lad_i[1:0]} + 3'h1, wait_i, !wr_oe_i};
                end
                // Ready low one bus state, data with it
                if (nl != 3'h0 && (den_oe_i || ads_oe_i)) begin
                    if (nw == 2'h0) begin
                        ready_n_o <= 1'b0;
                        drive_q <= !nwr;
                        if (!nwr) drv_q <= mem_q[ni];
                        nw = wait_i;
                    end else nw = nw - 2'h1;
                end
                {idx_q, left_q, wt_q, wr_q} <= {ni, nl, nw, nwr};
            end
        end
    end
endmodule

/* File: testbench/test_local_bus_master_interface.sv */
// Self-checking bench of the local bus master
`timescale 1ns/1ns
module test_local_bus_master_interface import lbm_pkg::*;;
    logic clk_i, arst_n_i, req_valid_i, req_ready_o, rd_valid_o, bus_clk_o, lad_oe, ale_n_o, ale_oe, ads_oe;
    logic dir_oe, den_oe, wr_oe, ready_n, lock_n, lock_oe, cache_o, cache_oe, foreign, saw_full;
    logic [31:0] lad_w, lad_o, ref_mem [16];
    logic [3:0] be_oe;
    logic [1:0] wait_q;
    logic [15:0] lf;
    lbm_req_s req_i, r;
    lbm_rdata_s rd_o;
    lbm_req_s ops_q [$];
    logic [32:0] rq [$];
    int fail_count, compares, addr_seen, n;
    logic [3:0] be_tab [10] = '{4'hf, 4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hc, 4'h7, 4'he};
    lbm_master dut_u (.*, .shared_addr_data_lines_i(lad_w), .shared_addr_data_lines_o(lad_o),
        .shared_addr_data_lines_oe_o(lad_oe), .ale_oe_o(ale_oe), .address_status_strobe_n_o(),
        .address_status_strobe_oe_o(ads_oe), .transfer_direction_o(), .transfer_direction_oe_o(dir_oe),
        .transceiver_enable_n_o(), .transceiver_enable_oe_o(den_oe), .write_read_o(), .write_read_oe_o(wr_oe),
        .byte_lane_strobes_n_o(), .byte_lane_strobes_oe_o(be_oe), .ready_n_i(ready_n), .lock_n_i(lock_n),
        .lock_n_o(), .lock_oe_o(lock_oe), .cache_oe_o(cache_oe));
    lbm_bus_partner mem_u (.clk_i, .arst_n_i, .bus_clk_i(bus_clk_o), .lad_i(lad_o),
        .lad_oe_i(lad_oe), .ads_oe_i(ads_oe), .den_oe_i(den_oe), .wr_oe_i(wr_oe), .be_oe_i(be_oe),
        .lock_oe_i(lock_oe), .wait_i(wait_q), .foreign_lock_i(foreign), .lad_o(lad_w), .ready_n_o(ready_n),
        .lock_n_o(lock_n));
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Reference model: memory, read words, address order
    task automatic send(input lbm_req_s q);
        logic [3:0] ix;
        for (int w = 0; w <= q.size; w++) begin
            ix = q.addr[3:0] + w[3:0];
            for (int b = 0; b < 4; b++) if (q.write && q.be[w][b]) ref_mem[ix][8*b +: 8] = q.wdata[w][8*b +: 8];
            if (!q.write) rq.push_back({ref_mem[ix], w == q.size});
        end
        ops_q.push_back(q);
        req_i <= q;
        req_valid_i <= 1'b1;
        @(negedge clk_i);
        while (req_ready_o !== 1'b1) @(negedge clk_i);
        @(posedge clk_i);
    endtask
    always @(negedge clk_i) begin
        if (req_valid_i && req_ready_o === 1'b0) saw_full = 1'b1;
        if (ale_n_o === 1'b0) begin
            r = ops_q.size() ? ops_q.pop_front() : 'x;
            addr_seen++;
            check(lad_o, {r.addr, r.size});
            check({wr_oe, dir_oe}, {2{!r.write}});
            check(be_oe, r.be[0]);
            check({cache_oe, cache_o}, {1'b1, r.cache});
            check(lock_oe, r.lock_op inside {2'h1, 2'h3});
        end
        if (rd_valid_o === 1'b1) check(rd_o, rq.size() ? rq.pop_front() : 'x);
    end
    initial begin
        clk_i = 1'b0;
        forever #(LBM_CLK_PERIOD_NS / 2) clk_i = ~clk_i;
    end
    initial begin
        #200000;
        fail_count++;
        summarize();
    end
    initial begin
        {arst_n_i, req_valid_i, foreign, saw_full, wait_q} = '0;
        req_i = '0;
        lf = 16'h000f;
        for (int k = 0; k < 16; k++) ref_mem[k] = 32'h5a00_0000 | k;
        repeat (16) @(posedge clk_i);
        arst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        // Random back-to-back traffic fills the buffer
        for (int i = 0; i < 48; i++) begin
            lf = lfsr(lf);
            r = '0;
            r.addr = {26'h0, lf[3:2], 2'h0};
            r.size = lf[5:4];
            r.write = lf[6];
            r.cache = lf[7];
            r.lock_op = (i % 8 == 3) ? 2'h1 : (i % 8 == 4) ? 2'h2 : (i % 8 == 6) ? 2'h3 : 2'h0;
            if (r.lock_op != 2'h0) r.write = (r.lock_op == 2'h2);
            for (int w = 0; w < 4; w++) {r.be[w], r.wdata[w]} = {be_tab[(lf >> (3 * w)) % 10], lf, lf ^ w[15:0]};
            wait_q <= lf[9:8];
            send(r);
        end
        req_valid_i <= 1'b0;
        repeat (200) @(posedge clk_i);
        check(saw_full, 1'b1);
        // Locked read waits out a foreign lock
        foreign <= 1'b1;
        repeat (4) @(posedge clk_i);
        r = '0;
        r.lock_op = 2'h1;
        n = addr_seen;
        send(r);
        req_valid_i <= 1'b0;
        repeat (40) @(posedge clk_i);
        check(addr_seen, n);
        foreign <= 1'b0;
        repeat (40) @(posedge clk_i);
        check(addr_seen, n + 1);
        r.lock_op = 2'h2;
        r.write = 1'b1;
        send(r);
        req_valid_i <= 1'b0;
        repeat (100) @(posedge clk_i);
        check({ops_q.size(), rq.size()}, 0);
        summarize();
    end
endmodule
